// file: hw/vrc_params.svh
/*
  Constants of the volatile read-settings register and the fast-read path:
  field positions, reset value, wrap and dummy codes, command codes.
  Assumes it is included by bare name after the settings package.
*/
// Summary of operation
// (RL1) Bits 7:4 set dummy clocks between address and data of fast reads.
// (RL2) Dummy codes 0000 and 1111 both mean the default count.
// (RL3) Host picks dummy count enough for its clock, else data is wrong.
// (RL4) Single fast read: 54/95/105/108 MHz with 1/2/3/4+ dummies.
// (RL5) Quad I/O fast read: 20 MHz at one dummy, ten for 108 MHz.
// (RL6) Bit 3 low enables execute-in-place; defaults high, disabled.
// (RL7) Feature digit 2 or 4 ignores bit 3, always execute-in-place.
// (RL8) Wrap field 1:0 code 11, the default, reads on sequentially.
// (RL9) Wrap code 00 cycles inside the aligned 16-byte block.
// (RL10) Wrap code 01 cycles inside the aligned 32-byte block.
// (RL11) Wrap code 10 cycles inside the aligned 64-byte block.
// (RL12) A register write takes effect at once, no power cycle.
// (RL13) Register read and written only by its own two commands.
// (RL14) Protocol bits 3:2: both low quad, bit 2 dual, at power-up.
// (RL15) Codes 0001..1110 give that many dummies; default suits full speed.
`ifndef VRC_PARAMS_SVH
`define VRC_PARAMS_SVH

// register layout
`define VRC_RESET_VALUE 8'hFB
`define VRC_DUMMY_MSB 7
`define VRC_DUMMY_LSB 4
`define VRC_IN_PLACE_BIT 3
`define VRC_RSVD_BIT 2
`define VRC_WRAP_MSB 1
`define VRC_WRAP_LSB 0

// dummy field codes meaning the default count
`define VRC_DUMMY_DEF_LO 4'h0
`define VRC_DUMMY_DEF_HI 4'hF

// wrap field codes
`define VRC_WRAP_16 2'h0
`define VRC_WRAP_32 2'h1
`define VRC_WRAP_64 2'h2
`define VRC_WRAP_SEQ 2'h3
`define VRC_MASK_16 24'h00000F
`define VRC_MASK_32 24'h00001F
`define VRC_MASK_64 24'h00003F

// default dummy counts, enough for the top clock per variant
`define VRC_DEF_DUMMY_FR 4'h4
`define VRC_DEF_DUMMY_DOFR 4'h5
`define VRC_DEF_DUMMY_DIOFR 4'h7
`define VRC_DEF_DUMMY_QOFR 4'h7
`define VRC_DEF_DUMMY_QIOFR 4'hA

// command codes
`define VRC_CMD_FAST_READ 8'h0B
`define VRC_CMD_DUAL_OUT_READ 8'h3B
`define VRC_CMD_DUAL_IO_READ 8'hBB
`define VRC_CMD_QUAD_OUT_READ 8'h6B
`define VRC_CMD_QUAD_IO_READ 8'hEB
`define VRC_CMD_WRITE_SETTINGS 8'h81
`define VRC_CMD_READ_SETTINGS 8'h85

// phase lengths in bits
`define VRC_CMD_BITS 5'd8
`define VRC_ADDR_BITS 5'd24
`define VRC_BYTE_BITS 4'd8

`endif

// file: hw/vrc_pkg.sv
/*
  Types shared by the read-settings block: register layout, link states,
  lane widths. Assumes nothing of its surroundings.
*/
package vrc_pkg;

  // volatile read-settings register, bit 7 first
  typedef struct packed {
    logic [3:0] dummy;
    logic in_place_off;
    logic reserved;
    logic [1:0] wrap;
  } settings_t;

  // number of data lanes in use for a phase
  typedef enum logic [1:0] {LANES_1, LANES_2, LANES_4} lane_width_t;

  // link-side frame sequencer
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_REG_IN, ST_REG_OUT, ST_IGNORE
  } link_state_t;

endpackage

// file: hw/wrap_address_step.sv
/*
  Next byte address of a burst read under the wrap setting.
  Assumes a 24-bit byte address; purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vrc_params.svh"

module wrap_address_step (
  // current address and wrap code
  input wire logic [23:0] i_addr,
  input wire logic [1:0] i_wrap,
  // address of the following byte
  output logic [23:0] o_next
);
  logic [23:0] mask;
  logic [23:0] inc;

  // pick the aligned block size; sequential rolls over the whole array
  always_comb begin
    inc = i_addr + 24'h000001;
    unique case (i_wrap)
      `VRC_WRAP_16: mask = `VRC_MASK_16; // RL9
      `VRC_WRAP_32: mask = `VRC_MASK_32; // RL10
      `VRC_WRAP_64: mask = `VRC_MASK_64; // RL11
      `VRC_WRAP_SEQ: mask = 24'hFFFFFF; // RL8
    endcase
    o_next = (i_addr & ~mask) | (inc & mask);
  end

endmodule // wrap_address_step
`default_nettype wire

// file: hw/volatile_read_config_wrap.sv
/*
  Volatile read-settings register of a serial flash and the fast-read
  path it steers: dummy count, execute-in-place, wrapped bursts.
  Assumes the serial clock i_sclk is a separate domain from i_clock,
  that the array answers i_fetch_data combinationally from o_fetch_addr
  within one serial clock, and that the nonvolatile protocol bits sit
  still on i_nv_protocol around reset.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vrc_params.svh"

module volatile_read_config_wrap #(
  parameter int FEATURE_DIGIT = 1
) (
  // system clock side
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [1:0] i_nv_protocol,
  output vrc_pkg::settings_t o_settings,
  output logic o_execute_in_place_mode,
  output vrc_pkg::lane_width_t o_protocol,
  // serial link
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_dq,
  output logic [3:0] o_dq,
  output logic [3:0] o_dq_oe,
  // array fetch, serial clock domain
  output logic [23:0] o_fetch_addr,
  input wire logic [7:0] i_fetch_data
);
  import vrc_pkg::*;

  localparam logic IN_PLACE_FORCED = (FEATURE_DIGIT == 2) ||
                                     (FEATURE_DIGIT == 4);

  // system domain state
  logic [1:0] nv_meta_reg;
  logic [1:0] nv_sync_reg;
  logic [1:0] proto_reg;
  logic tog_meta_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;

  // link domain state
  logic lrst_meta_reg;
  logic lrst_reg;
  logic [1:0] proto_meta_reg;
  logic [1:0] proto_link_reg;
  settings_t cfg_link_reg;
  logic wr_toggle_reg;
  logic in_place_armed_reg;
  logic [7:0] cmd_reg;
  link_state_t state_reg;
  logic [4:0] bits_reg;
  logic [23:0] sh_reg;
  logic [3:0] dcnt_reg;
  logic [7:0] rem_reg;
  logic [3:0] left_reg;

  // link combinational
  link_state_t eff_state;
  lane_width_t proto_w;
  lane_width_t addr_w;
  lane_width_t data_w;
  lane_width_t cur_w;
  logic [3:0] dummy_n;
  logic [2:0] n_in;
  logic [23:0] sh_next;
  logic [4:0] bits_next;
  logic [7:0] byte_src;
  logic [7:0] emit_src;
  logic [3:0] emit_left;
  logic [3:0] emit_lanes;
  logic [3:0] emit_oe;
  logic [7:0] emit_rem;
  logic is_fast_read;
  logic cmd_done;
  logic confirm_evt;
  logic wr_evt;
  logic [7:0] wr_value;
  logic [23:0] next_addr;
  logic in_place_allowed;

  // lane count of a protocol setting: quad wins when both bits are low
  function automatic lane_width_t proto_width(input logic [1:0] p);
    if (!p[1]) begin
      proto_width = LANES_4; // RL14
    end else if (!p[0]) begin
      proto_width = LANES_2; // RL14
    end else begin
      proto_width = LANES_1;
    end
  endfunction

  // system side: nonvolatile protocol pins pass two flops first
  always_ff @(posedge i_clock) begin
    nv_meta_reg <= i_nv_protocol;
    nv_sync_reg <= nv_meta_reg;
  end

  // protocol is caught only while reset is held, i.e. at power-up
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      proto_reg <= nv_sync_reg; // RL14
      o_protocol <= proto_width(nv_sync_reg);
    end
  end

  // write event from the link arrives as a toggle
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      tog_meta_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end else begin
      tog_meta_reg <= wr_toggle_reg;
      tog_s2_reg <= tog_meta_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end

  // mirror of the register; link value is stable long before toggle lands
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_settings <= settings_t'(`VRC_RESET_VALUE);
    end else if (tog_s2_reg ^ tog_s3_reg) begin
      o_settings <= cfg_link_reg; // RL12
    end
  end

  // execute-in-place view for the rest of the chip
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_execute_in_place_mode <= IN_PLACE_FORCED;
    end else begin
      o_execute_in_place_mode <= IN_PLACE_FORCED ||
                                 !o_settings.in_place_off; // RL6 RL7
    end
  end

  // link side reset and protocol bits, each through two flops
  always_ff @(posedge i_sclk) begin
    lrst_meta_reg <= i_srst;
    lrst_reg <= lrst_meta_reg;
    proto_meta_reg <= proto_reg;
    proto_link_reg <= proto_meta_reg;
  end

  // a frame armed for execute-in-place starts straight at the address
  always_comb begin
    eff_state = state_reg;
    if (state_reg == ST_CMD && in_place_armed_reg) begin
      eff_state = ST_ADDR;
    end
  end

  // lane widths of each phase from the command and the protocol
  always_comb begin
    proto_w = proto_width(proto_link_reg);
    addr_w = proto_w;
    data_w = proto_w;
    dummy_n = `VRC_DEF_DUMMY_FR;
    if (proto_w == LANES_1) begin
      unique case (cmd_reg)
        `VRC_CMD_DUAL_OUT_READ: data_w = LANES_2;
        `VRC_CMD_DUAL_IO_READ: begin
          addr_w = LANES_2;
          data_w = LANES_2;
        end
        `VRC_CMD_QUAD_OUT_READ: data_w = LANES_4;
        `VRC_CMD_QUAD_IO_READ: begin
          addr_w = LANES_4;
          data_w = LANES_4;
        end
        default: data_w = LANES_1;
      endcase
    end
    // default count per variant, enough for full clock rate
    unique case (cmd_reg)
      `VRC_CMD_DUAL_OUT_READ: dummy_n = `VRC_DEF_DUMMY_DOFR; // RL15
      `VRC_CMD_DUAL_IO_READ: dummy_n = `VRC_DEF_DUMMY_DIOFR; // RL15
      `VRC_CMD_QUAD_OUT_READ: dummy_n = `VRC_DEF_DUMMY_QOFR; // RL15
      `VRC_CMD_QUAD_IO_READ: dummy_n = `VRC_DEF_DUMMY_QIOFR; // RL15
      default: dummy_n = `VRC_DEF_DUMMY_FR; // RL15
    endcase
    // both default codes alike, any other code is the count itself
    if (cfg_link_reg.dummy != `VRC_DUMMY_DEF_LO &&
        cfg_link_reg.dummy != `VRC_DUMMY_DEF_HI) begin // RL2
      dummy_n = cfg_link_reg.dummy; // RL1 RL15
    end
  end

  // sampling and emitting for the current phase
  always_comb begin
    unique case (eff_state)
      ST_ADDR: cur_w = addr_w;
      ST_DUMMY, ST_DATA: cur_w = data_w;
      default: cur_w = proto_w;
    endcase
    unique case (cur_w)
      LANES_1: begin
        n_in = 3'd1;
        sh_next = {sh_reg[22:0], i_dq[0]};
      end
      LANES_2: begin
        n_in = 3'd2;
        sh_next = {sh_reg[21:0], i_dq[1:0]};
      end
      default: begin // quad, and the unused code
        n_in = 3'd4;
        sh_next = {sh_reg[19:0], i_dq};
      end
    endcase
    bits_next = bits_reg + {2'b00, n_in};
    byte_src = (eff_state == ST_DUMMY || eff_state == ST_DATA) ?
               i_fetch_data : cfg_link_reg;
    emit_src = (left_reg == 4'h0) ? byte_src : rem_reg;
    emit_left = ((left_reg == 4'h0) ? `VRC_BYTE_BITS : left_reg) -
                {1'b0, n_in};
    // single line answers on lane 1, wider ones from lane 0 up
    unique case (cur_w)
      LANES_1: begin
        emit_lanes = {2'b00, emit_src[7], 1'b0};
        emit_oe = 4'h2;
        emit_rem = {emit_src[6:0], 1'b0};
      end
      LANES_2: begin
        emit_lanes = {2'b00, emit_src[7:6]};
        emit_oe = 4'h3;
        emit_rem = {emit_src[5:0], 2'b00};
      end
      default: begin // quad, and the unused code
        emit_lanes = emit_src[7:4];
        emit_oe = 4'hF;
        emit_rem = {emit_src[3:0], 4'h0};
      end
    endcase
  end

  // command decode and the events that touch persistent state
  always_comb begin
    is_fast_read = (sh_next[7:0] == `VRC_CMD_FAST_READ) ||
                   (sh_next[7:0] == `VRC_CMD_DUAL_OUT_READ) ||
                   (sh_next[7:0] == `VRC_CMD_DUAL_IO_READ) ||
                   (sh_next[7:0] == `VRC_CMD_QUAD_OUT_READ) ||
                   (sh_next[7:0] == `VRC_CMD_QUAD_IO_READ);
    cmd_done = (eff_state == ST_CMD) && (bits_next == `VRC_CMD_BITS);
    confirm_evt = (eff_state == ST_DUMMY) && (dcnt_reg == dummy_n);
    wr_evt = (eff_state == ST_REG_IN) && (bits_next == `VRC_CMD_BITS);
    wr_value = sh_next[7:0] & ~(8'h01 << `VRC_RSVD_BIT);
    in_place_allowed = IN_PLACE_FORCED ||
                       !cfg_link_reg.in_place_off; // RL6 RL7
  end

  // next burst address under the wrap setting
  wrap_address_step u_wrap (
    .i_addr(o_fetch_addr),
    .i_wrap(cfg_link_reg.wrap),
    .o_next(next_addr)
  );

  // settings that outlive a frame; chip select leaves them, a link reset loads their reset values
  always_ff @(posedge i_sclk) begin
    if (lrst_reg) begin
      cfg_link_reg <= settings_t'(`VRC_RESET_VALUE);
      wr_toggle_reg <= 1'b0;
      in_place_armed_reg <= 1'b0;
      cmd_reg <= `VRC_CMD_FAST_READ;
    end else begin
      if (cmd_done && is_fast_read) begin
        cmd_reg <= sh_next[7:0];
      end
      // first dummy edge carries the confirmation bit, low keeps it
      if (confirm_evt) begin
        in_place_armed_reg <= in_place_allowed && !i_dq[0]; // RL6 RL7
      end
      if (wr_evt) begin
        cfg_link_reg <= settings_t'(wr_value); // RL12 RL13
        wr_toggle_reg <= ~wr_toggle_reg;
      end
    end
  end

  // frame sequencer; chip select high ends the frame at once
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      state_reg <= ST_CMD;
      bits_reg <= 5'd0;
      sh_reg <= 24'h000000;
      dcnt_reg <= 4'h0;
      rem_reg <= 8'h00;
      left_reg <= 4'h0;
      o_dq <= 4'h0;
      o_dq_oe <= 4'h0;
      o_fetch_addr <= 24'h000000;
    end else begin
      sh_reg <= sh_next;
      bits_reg <= bits_next;
      unique case (eff_state)
        ST_CMD: begin
          if (cmd_done) begin
            bits_reg <= 5'd0;
            if (is_fast_read) begin
              state_reg <= ST_ADDR;
            end else if (sh_next[7:0] == `VRC_CMD_WRITE_SETTINGS) begin
              state_reg <= ST_REG_IN; // RL13
            end else if (sh_next[7:0] == `VRC_CMD_READ_SETTINGS) begin
              state_reg <= ST_REG_OUT; // RL13
              o_dq <= emit_lanes;
              o_dq_oe <= emit_oe;
              rem_reg <= emit_rem;
              left_reg <= emit_left;
            end else begin
              state_reg <= ST_IGNORE;
            end
          end
        end
        ST_ADDR: begin
          if (bits_next == `VRC_ADDR_BITS) begin
            o_fetch_addr <= sh_next;
            state_reg <= ST_DUMMY;
            dcnt_reg <= dummy_n;
          end
        end
        ST_DUMMY: begin
          // first data goes out on the last dummy edge
          dcnt_reg <= dcnt_reg - 4'h1;
          if (dcnt_reg == 4'h1) begin // RL1
            state_reg <= ST_DATA;
            o_dq <= emit_lanes;
            o_dq_oe <= emit_oe;
            rem_reg <= emit_rem;
            left_reg <= emit_left;
            o_fetch_addr <= next_addr;
          end
        end
        ST_DATA: begin
          o_dq <= emit_lanes;
          rem_reg <= emit_rem;
          left_reg <= emit_left;
          if (left_reg == 4'h0) begin
            o_fetch_addr <= next_addr; // RL8 RL9 RL10 RL11
          end
        end
        ST_REG_OUT: begin
          // register repeats for as long as the frame lasts
          o_dq <= emit_lanes;
          rem_reg <= emit_rem;
          left_reg <= emit_left;
        end
        ST_REG_IN: begin
          if (wr_evt) begin
            state_reg <= ST_IGNORE;
          end
        end
        ST_IGNORE: begin
          bits_reg <= 5'd0;
        end
      endcase
    end
  end

endmodule // volatile_read_config_wrap
`default_nettype wire

// file: sim/vrc_checker_assertions.sv
/*
  Port checker of the read-settings block.
  Assumes it is bound into every instance of the block.
*/
`timescale 1ns/100ps
`default_nettype none

module vrc_checker #(
  parameter int FEATURE_DIGIT = 1
) (
  // system side
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [1:0] i_nv_protocol,
  input wire vrc_pkg::settings_t o_settings,
  input wire logic o_execute_in_place_mode,
  input wire vrc_pkg::lane_width_t o_protocol,
  // serial link and fetch
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_dq,
  input wire logic [3:0] o_dq,
  input wire logic [3:0] o_dq_oe,
  input wire logic [23:0] o_fetch_addr,
  input wire logic [7:0] i_fetch_data
);
  import vrc_pkg::*;
  logic forced, xd, seen;
  logic [23:0] pa, wm;

  // wrap mask taken from the mirror; stable during bursts
  assign forced = (FEATURE_DIGIT == 2) || (FEATURE_DIGIT == 4);
  assign xd = o_settings.in_place_off;
  assign wm = o_settings.wrap == 2'h0 ? 24'h00000F :
    o_settings.wrap == 2'h1 ? 24'h00001F :
    o_settings.wrap == 2'h2 ? 24'h00003F : 24'hFFFFFF;

  // previous fetch address; first load of a frame is not a step
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      seen <= 1'b0;
      pa <= 24'h000000;
    end else begin
      pa <= o_fetch_addr;
      seen <= seen || (o_fetch_addr != 24'h000000);
    end
  end

  chk_in_place_follow: assert property (@(posedge i_clock) disable iff (i_srst)
    o_execute_in_place_mode == (forced || !$past(xd)))
    else $error("in place flag does not follow setting");
  chk_reset_value: assert property (@(posedge i_clock) disable iff (i_srst)
    $fell(i_srst) |-> o_settings == 8'hFB)
    else $error("settings not at default after reset");
  chk_rsvd_zero: assert property (@(posedge i_clock) disable iff (i_srst)
    o_settings.reserved == 1'b0)
    else $error("reserved setting bit not zero");
  chk_oe_idle: assert property (@(posedge i_clock) disable iff (i_srst)
    i_cs_n |-> o_dq_oe == 4'h0)
    else $error("lanes driven while deselected");
  chk_fetch_idle: assert property (@(posedge i_clock) disable iff (i_srst)
    i_cs_n |-> o_fetch_addr == 24'h000000)
    else $error("fetch address not cleared while deselected");
  chk_protocol_hold: assert property (@(posedge i_clock) disable iff (i_srst)
    $stable(o_protocol))
    else $error("protocol changed outside reset");
  chk_protocol_map: assert property (@(posedge i_clock) disable iff (i_srst)
    $fell(i_srst) |-> o_protocol == (!i_nv_protocol[1] ? LANES_4 :
    !i_nv_protocol[0] ? LANES_2 : LANES_1))
    else $error("protocol does not match pins");
  chk_wrap_step: assert property (@(posedge i_sclk) disable iff (i_srst)
    seen && !i_cs_n && o_fetch_addr != pa |->
    o_fetch_addr == ((pa & ~wm) | ((pa + 24'h000001) & wm)))
    else $error("burst address step wrong");

  cover property (@(posedge i_clock) $changed(o_settings));
  cover property (@(posedge i_clock) $rose(o_execute_in_place_mode));
  cover property (@(posedge i_sclk) seen && o_fetch_addr < pa);
endmodule // vrc_checker

bind volatile_read_config_wrap vrc_checker #(
  .FEATURE_DIGIT(FEATURE_DIGIT)
) u_vrc_checker (
  .i_clock(i_clock), .i_srst(i_srst), .i_nv_protocol(i_nv_protocol),
  .o_settings(o_settings),
  .o_execute_in_place_mode(o_execute_in_place_mode),
  .o_protocol(o_protocol), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_dq(i_dq),
  .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_fetch_addr(o_fetch_addr),
  .i_fetch_data(i_fetch_data)
);

`default_nettype wire

// file: sim/serial_host_model.sv
/*
  Serial host model: single-line frames, data launched on the low clock.
  Assumes the bench resolves the lanes and returns the wire levels.
*/
`timescale 1ns/100ps
`default_nettype none

module serial_host_model (
  // serial link
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_dq,
  input wire logic [3:0] i_dq
);
  // 6.25 MHz serial clock, slow enough for any dummy count
  localparam time HALF = 80;
  // lane 0 level in dummy cycles; low keeps execute-in-place armed
  logic dummy_level = 1'b1;

  // clock parked low, link deselected
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_dq = 4'h5;
  end

  // deselected clock pulses, only around reset
  task automatic idle(input int n);
    repeat (n) begin
      #HALF o_sclk = 1'b1;
      #HALF o_sclk = 1'b0;
    end
  endtask

  // command and payload out, dummies, then n_rx bits from lane 1
  task automatic frame(input logic [31:0] tx, input int n_tx,
    input int n_dum, input int n_rx, output logic [31:0] rx);
    rx = 32'h00000000;
    o_cs_n = 1'b0;
    for (int i = 0; i < n_tx + n_dum + n_rx - (n_rx > 0); i++) begin
      // idle lanes toggle so a stale level is never mistaken for data
      if (i < n_tx) o_dq = {~o_dq[3:1], tx[31 - i]};
      else o_dq = {~o_dq[3:1], dummy_level};
      #HALF o_sclk = 1'b1;
      #HALF o_sclk = 1'b0;
      if (i >= n_tx + n_dum - 1) rx = {rx[30:0], i_dq[1]};
    end
    #HALF o_cs_n = 1'b1;
    o_dq = ~o_dq;
    #(2 * HALF);
  endtask
endmodule // serial_host_model

`default_nettype wire

// file: sim/volatile_read_config_wrap_test.sv
/*
  Bench of the read-settings block: reset, register access, bursts.
  Assumes the host model and the checker are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none

module volatile_read_config_wrap_test;
  import vrc_pkg::*;
  logic i_clock, i_srst, sclk, cs_n, in_place;
  logic [1:0] nv;
  logic [3:0] host_dq, dq_o, dq_oe, dq_w;
  logic [23:0] fetch_addr;
  logic [7:0] fetch_data;
  settings_t settings;
  lane_width_t proto;
  lane_width_t pexp [4] = '{LANES_4, LANES_4, LANES_2, LANES_1};
  int n_fail = 0;
  int n_tests = 0;

  // lane levels from every driver; array byte is the low byte of its address
  assign dq_w = (dq_oe & dq_o) | (~dq_oe & host_dq);
  assign fetch_data = fetch_addr[7:0];

  volatile_read_config_wrap #(.FEATURE_DIGIT(1)) u_volatile_read_config_wrap (
    .i_clock(i_clock), .i_srst(i_srst), .i_nv_protocol(nv),
    .o_settings(settings), .o_execute_in_place_mode(in_place),
    .o_protocol(proto),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_dq(dq_w), .o_dq(dq_o),
    .o_dq_oe(dq_oe), .o_fetch_addr(fetch_addr), .i_fetch_data(fetch_data)
  );
  serial_host_model u_serial_host_model (
    .o_sclk(sclk), .o_cs_n(cs_n), .o_dq(host_dq), .i_dq(dq_w)
  );

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // link needs its own edges while reset is seen
  task automatic do_reset(input logic [1:0] v);
    @(posedge i_clock);
    #1 nv = v;
    i_srst = 1'b1;
    fork
      repeat (10) @(posedge i_clock);
      u_serial_host_model.idle(3);
    join
    @(posedge i_clock);
    #1 i_srst = 1'b0;
    u_serial_host_model.idle(3);
  endtask

  // write then wait, bounded, for the system-side mirror
  task automatic write_cfg(input logic [7:0] v);
    logic [31:0] rx;
    int k;
    u_serial_host_model.frame({8'h81, v, 16'h0000}, 16, 0, 0, rx);
    for (k = 0; k < 40 && settings !== (v & 8'hFB); k++) begin
      @(posedge i_clock);
      #1;
    end
    check("settings", settings, v & 8'hFB);
    if (settings !== (v & 8'hFB)) wrap_up();
  endtask

  function automatic logic [23:0] nxt(input logic [23:0] a,
    input logic [1:0] w);
    logic [23:0] m;
    m = w == 2'h0 ? 24'h00000F : w == 2'h1 ? 24'h00001F :
      w == 2'h2 ? 24'h00003F : 24'hFFFFFF;
    return (a & ~m) | ((a + 24'h000001) & m);
  endfunction

  task automatic t_protocol;
    for (int v = 0; v < 4; v++) begin
      do_reset(v[1:0]);
      check("protocol", proto, pexp[v]);
      check("reset value", settings, 8'hFB);
      check("in place at reset", in_place, 1'b0);
    end
    $display("protocol and reset test done");
  endtask

  task automatic t_regs;
    logic [7:0] v [2] = '{8'h26, 8'h0F};
    logic [31:0] rx;
    for (int i = 0; i < 2; i++) begin
      write_cfg(v[i]);
      @(posedge i_clock);
      #1 check("in place", in_place, !v[i][3]);
      u_serial_host_model.frame({8'h85, 24'h0}, 8, 0, 8, rx);
      check("readback", rx[7:0], v[i] & 8'hFB);
    end
    $display("register test done");
  endtask

  // one burst per wrap code, each with its own dummy code
  task automatic t_bursts;
    logic [3:0] dc [4] = '{4'h0, 4'hF, 4'h1, 4'hE};
    logic [23:0] sa [4] = '{24'h12340F, 24'h00001F, 24'hABCDBF, 24'hFFFFFF};
    logic [23:0] a1, a2;
    logic [31:0] rx;
    int nd;
    for (int w = 0; w < 4; w++) begin
      write_cfg({dc[w], 2'b10, w[1:0]});
      nd = (dc[w] == 4'h0 || dc[w] == 4'hF) ? 4 : int'(dc[w]);
      a1 = nxt(sa[w], w[1:0]);
      a2 = nxt(a1, w[1:0]);
      u_serial_host_model.frame({8'h0B, sa[w]}, 32, nd, 24, rx);
      check("burst", rx[23:0], {sa[w][7:0], a1[7:0], a2[7:0]});
    end
    $display("burst test done");
  endtask

  // low confirmation bit arms the mode, next frame skips the command
  task automatic t_in_place;
    logic [31:0] rx;
    write_cfg(8'h03);
    u_serial_host_model.dummy_level = 1'b0;
    u_serial_host_model.frame({8'h0B, 24'h000010}, 32, 4, 8, rx);
    check("arming read", rx[7:0], 8'h10);
    u_serial_host_model.frame({24'h000020, 8'h00}, 24, 4, 8, rx);
    check("in place read", rx[7:0], 8'h20);
    u_serial_host_model.dummy_level = 1'b1;
    u_serial_host_model.frame({24'h000030, 8'h00}, 24, 4, 8, rx);
    check("leaving read", rx[7:0], 8'h30);
    u_serial_host_model.frame({8'h0B, 24'h000040}, 32, 4, 8, rx);
    check("read after leaving", rx[7:0], 8'h40);
    $display("execute in place test done");
  endtask

  initial begin
    i_srst = 1'b1;
    nv = 2'b11;
    t_protocol();
    t_regs();
    t_bursts();
    t_in_place();
    wrap_up();
  end
endmodule // volatile_read_config_wrap_test

`default_nettype wire
